// ---- bench/ast_remote_node.sv ----
// remote serial node: sends characters, decodes the device's line
`timescale 1ns/1ns
`default_nettype none
module ast_remote_node (
  input wire logic aclk, // clock
  input wire logic txd, // line from device
  output logic rxd, // line to device, idle high
  output logic cts_n // clear to send
);
  localparam int BIT = 16; // clocks per bit, divider 1
  logic [8:0] got_ff;
  int got_n;
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b0;
    got_n = 0;
    got_ff = '0;
  end
  task automatic set_cts(input logic v);
    @(posedge aclk);
    cts_n <= v;
  endtask
  // stop level 0 forces a framing fault, or a break if every sent bit is zero
  task automatic send(input logic [8:0] ch, input int nb, input logic sl);
    @(posedge aclk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < nb; i++)
    begin
      rxd <= ch[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= sl;
    repeat (BIT) @(posedge aclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge aclk);
  endtask
  // nine samples: parity, address bit or first stop
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge aclk);
      got_ff[i] = txd;
    end
    got_n++;
  end
endmodule
`default_nettype wire

// ---- bench/ast_uart_monitor.sv ----
// port-level checks for the serial transceiver
`timescale 1ns/1ns
`default_nettype none
module ast_uart_monitor (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic txd, // line out
  input wire logic cts_n, // clear to send
  input wire logic driver_enable, // transceiver enable
  input wire logic tx_irq, // tx irq
  input wire logic rx_irq, // rx irq
  input wire logic timer_irq // timer irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet:
    assert property ($rose(aresetn) |-> txd && !driver_enable && !tx_irq
      && !rx_irq && !timer_irq) else $error("outputs busy after reset");
  a_low_needs_de:
    assert property (!txd |-> driver_enable)
    else $error("line driven without driver enable");
  // lead bounds hold for divider 1 only; a held-off start is excluded
  a_de_lead_time:
    assert property ($rose(driver_enable) && !cts_n |-> txd [*8] ##1
      txd [*7] ##[1:17] !txd) else $error("driver enable lead wrong");
  a_de_after_stop:
    assert property ($fell(driver_enable) |-> $past(txd) && $past(txd, 16))
    else $error("driver enable dropped inside frame");
  a_write_resp:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write response late");
  a_write_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      && s_axi_awready && s_axi_wready) else $error("write not released");
  a_read_resp:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
      && s_axi_arready) else $error("read not released");
  a_read_single:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  c_frame: cover property ($rose(driver_enable));
  c_rx_irq: cover property ($rose(rx_irq));
  c_timer: cover property ($rose(timer_irq));
endmodule
bind ast_uart ast_uart_monitor u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .txd, .cts_n,
  .driver_enable, .tx_irq, .rx_irq, .timer_irq
);
`default_nettype wire

// ---- bench/tb_async_serial_transceiver.sv ----
// self-checking bench for the serial transceiver
`timescale 1ns/1ns
`default_nettype none
`include "ast_consts.svh"
module tb_async_serial_transceiver;
  logic aclk, aresetn, rxd, txd, cts_n, driver_enable;
  logic tx_irq, rx_irq, timer_irq;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int failures, tests_run;
  ast_uart DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rxd, .txd, .cts_n, .driver_enable, .tx_irq, .rx_irq, .timer_irq
  );
  ast_remote_node node (.aclk, .txd, .rxd, .cts_n);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [5:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  // upper bits always compared: they must read zero
  task automatic rc(input logic [5:0] a, input logic [7:0] m, e);
    rd(a);
    chk($sformatf("reg %h", a), {24'h0, e}, rdat & {24'hFF_FFFF, m});
  endtask
  task automatic wait_char(input int n0);
    for (int i = 0; i < 900; i++)
    begin
      if (node.got_n != n0 && driver_enable === 1'b0) break;
      @(posedge aclk);
    end
    chk("char seen", 32'h1, {31'h0, node.got_n != n0});
  endtask
  task automatic t_regs();
    rc(`AST_OFF_CTRL0, 8'hFF, `AST_CTRL_RST);
    rc(`AST_OFF_STAT0, 8'hFF, 8'h86);
    wr(`AST_OFF_BAUDHI, 8'h00);
    wr(`AST_OFF_BAUDLO, 8'h01);
    rc(`AST_OFF_BAUDLO, 8'hFF, 8'h01);
    rd(6'h24);
    chk("resp", {30'h0, `AST_RESP_SLVERR}, {30'h0, rrsp});
  endtask
  // ctrl0, ctrl1, data, expected nine bits seen on the line
  task automatic t_tx();
    logic [32:0] t [5] = '{{8'h19, 8'h00, 8'hA5, 9'h1A5},
      {8'h09, 8'h00, 8'h01, 9'h101}, {8'h21, 8'h00, 8'h5A, 9'h15A},
      {8'h01, 8'h03, 8'h00, 9'h100}, {8'h01, 8'h01, 8'hFF, 9'h0FF}};
    int n0;
    for (int i = 0; i < 5; i++)
    begin
      n0 = node.got_n;
      wr(`AST_OFF_CTRL1, t[i][24:17]);
      wr(`AST_OFF_CTRL0, t[i][32:25]);
      chk("tx_irq", 32'h1, {31'h0, tx_irq});
      wr(`AST_OFF_TXDATA, t[i][16:9]);
      rc(`AST_OFF_STAT0, 8'h02, 8'h00);
      wait_char(n0);
      chk("frame", {23'h0, t[i][8:0]}, {23'h0, node.got_ff});
    end
  endtask
  task automatic t_cts();
    int n0;
    n0 = node.got_n;
    node.set_cts(1'b1);
    wr(`AST_OFF_CTRL1, 8'h00);
    wr(`AST_OFF_CTRL0, 8'h05);
    wr(`AST_OFF_TXDATA, 8'h3C);
    repeat (400) @(posedge aclk);
    chk("held", n0, node.got_n);
    node.set_cts(1'b0);
    wait_char(n0);
    chk("frame", 32'h13C, {23'h0, node.got_ff});
  endtask
  task automatic t_rx();
    wr(`AST_OFF_CTRL0, 8'h00);
    node.send(9'h03C, 8, 1'b1);
    rc(`AST_OFF_STAT0, 8'h01, 8'h00);
    wr(`AST_OFF_CTRL0, 8'h02);
    node.send(9'h0C3, 8, 1'b1);
    rc(`AST_OFF_STAT0, 8'h01, 8'h01);
    chk("rx_irq", 32'h1, {31'h0, rx_irq});
    wr(`AST_OFF_CTRL1, 8'h10);
    chk("rx_irq", 32'h0, {31'h0, rx_irq});
    wr(`AST_OFF_CTRL1, 8'h00);
    rc(`AST_OFF_RXDATA, 8'hFF, 8'hC3);
    rc(`AST_OFF_STAT0, 8'h01, 8'h00);
    node.send(9'h055, 8, 1'b0);
    rc(`AST_OFF_STAT0, 8'h10, 8'h10);
    rd(`AST_OFF_RXDATA);
    node.send(9'h000, 8, 1'b0);
    rc(`AST_OFF_STAT0, 8'h08, 8'h08);
    rd(`AST_OFF_RXDATA);
    wr(`AST_OFF_CTRL0, 8'h0A);
    node.send(9'h001, 9, 1'b1);
    rc(`AST_OFF_STAT0, 8'h20, 8'h20);
    node.send(9'h0AA, 9, 1'b1);
    rc(`AST_OFF_STAT0, 8'h40, 8'h40);
    rd(`AST_OFF_RXDATA);
    wr(`AST_OFF_CTRL0, 8'h02);
    wr(`AST_OFF_ADDRCMP, 8'h5A);
    wr(`AST_OFF_CTRL1, 8'h09);
    node.send(9'h133, 9, 1'b1);
    rc(`AST_OFF_STAT0, 8'h01, 8'h00);
    node.send(9'h15A, 9, 1'b1);
    rc(`AST_OFF_STAT1, 8'h01, 8'h01);
    rc(`AST_OFF_RXDATA, 8'hFF, 8'h5A);
  endtask
  task automatic t_timer();
    wr(`AST_OFF_CTRL0, 8'h00);
    wr(`AST_OFF_CTRL1, 8'h20);
    repeat (4) @(posedge aclk);
    chk("timer_irq", 32'h1, {31'h0, timer_irq});
  endtask
  initial
  begin
    failures = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx();
    t_cts();
    t_rx();
    t_timer();
    final_report();
  end
  // whole run needs well under 8000 cycles
  initial
  begin
    #(40 * 30000);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

// ---- hw/ast_uart.sv ----
// asynchronous serial transceiver with axi4-lite register slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ast_consts.svh"
module ast_uart (
  input wire logic aclk, // system clock, 25 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection bits
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes, lane 0 used
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection bits
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rxd, // serial line in
  output logic txd, // serial line out, idle high
  input wire logic cts_n, // clear to send, active low
  output logic driver_enable, // transceiver enable, active high
  output logic tx_irq, // transmit interrupt level
  output logic rx_irq, // receive interrupt level
  output logic timer_irq // timer interrupt level
);
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [5:0] awaddr_ff, araddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] rd_val;
  logic [7:0] ctrl0_ff, ctrl1_ff, addr_cmp_ff, baud_hi_ff, baud_lo_ff;
  logic [15:0] baud_cnt_ff;
  logic tick, timer_active, timer_flag_ff, baud_run;
  logic transmit_enable, receive_enable, flow_control_enable;
  logic parity_enable, parity_odd, two_stop, multiproc_enable;
  logic addr_bit_tx, err_only, ninth_on;
  ast_pkg::ast_match_mode_t addr_match_mode;
  ast_pkg::ast_tx_state_e tx_state_ff;
  logic [4:0] tx_sub_ff;
  logic [2:0] tx_bit_ff;
  logic tx_stop_cnt_ff, tx_nine_ff, tx_bit_done, tx_leave_start;
  logic [7:0] tx_shift_ff, thr_ff;
  logic thr_full_ff, thr_mp_ff, cts_n_ff, cts_ok, tx_load;
  logic txd_ff, drv_pre_ff, drv_ff;
  ast_pkg::ast_rx_state_e rx_state_ff;
  logic [4:0] rx_sub_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_shift_ff, rx_data_ff;
  logic rx_nine_ff, rx_done_ff, rx_stop_ff, rx_sample;
  logic rx_data_avail_ff, rx_mp_ff, new_frame_ff, in_frame_ff;
  logic frame_err_ff, par_err_ff, overrun_ff, break_ff;
  logic is_break, is_addr, addr_hit, deliver, par_bad, rd_rxdata;

  assign transmit_enable = ctrl0_ff[`AST_C0_TX_EN];
  assign receive_enable = ctrl0_ff[`AST_C0_RX_EN];
  assign flow_control_enable = ctrl0_ff[`AST_C0_FLOW];
  assign parity_enable = ctrl0_ff[`AST_C0_PAR_EN];
  assign parity_odd = ctrl0_ff[`AST_C0_PAR_ODD];
  assign two_stop = ctrl0_ff[`AST_C0_TWO_STOP];
  assign multiproc_enable = ctrl1_ff[`AST_C1_MP_EN];
  assign addr_bit_tx = ctrl1_ff[`AST_C1_ADDR_BIT];
  assign addr_match_mode = ctrl1_ff[`AST_C1_MODE_HI:`AST_C1_MODE_LO];
  assign err_only = ctrl1_ff[`AST_C1_ERR_ONLY];
  assign ninth_on = parity_enable | multiproc_enable;

  // axi4-lite write channel: address and data taken in either order
  assign s_axi_awready = ~aw_got_ff;
  assign s_axi_wready = ~w_got_ff;
  assign wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_hit = (awaddr_ff <= `AST_OFF_BAUDLO) && (awaddr_ff[1:0] == 2'b00)
    && (awaddr_ff != `AST_OFF_RXDATA) && (awaddr_ff != `AST_OFF_STAT0)
    && (awaddr_ff != `AST_OFF_STAT1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `AST_RESP_OKAY;
      awaddr_ff <= 6'h00;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_got_ff)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_ff)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // control registers; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl0_ff <= `AST_CTRL_RST;
      ctrl1_ff <= `AST_CTRL_RST;
      addr_cmp_ff <= 8'h00;
      baud_hi_ff <= 8'(`AST_BAUD_RST >> 8);
      baud_lo_ff <= 8'(`AST_BAUD_RST);
    end
    else if (wr_go && wstrb0_ff)
    begin
      unique case (awaddr_ff)
        `AST_OFF_CTRL0: ctrl0_ff <= wdata_ff;
        `AST_OFF_CTRL1: ctrl1_ff <= wdata_ff;
        `AST_OFF_ADDRCMP: addr_cmp_ff <= wdata_ff;
        `AST_OFF_BAUDHI: baud_hi_ff <= wdata_ff;
        `AST_OFF_BAUDLO: baud_lo_ff <= wdata_ff;
        default: ;
      endcase
    end
  end

  // axi4-lite read channel, one cycle to rvalid
  assign s_axi_arready = ~rvalid_ff;
  assign rd_go = s_axi_arvalid & ~rvalid_ff;
  assign rd_rxdata = rd_go && (s_axi_araddr == `AST_OFF_RXDATA);
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `AST_OFF_RXDATA: rd_val = rx_data_ff;
      `AST_OFF_STAT0: rd_val = {~cts_n_ff, overrun_ff, par_err_ff,
        frame_err_ff, break_ff, tx_state_ff == ast_pkg::TX_IDLE,
        ~thr_full_ff, rx_data_avail_ff};
      `AST_OFF_CTRL0: rd_val = ctrl0_ff;
      `AST_OFF_CTRL1: rd_val = ctrl1_ff;
      `AST_OFF_STAT1: rd_val = {5'h00, timer_flag_ff, new_frame_ff, rx_mp_ff};
      `AST_OFF_ADDRCMP: rd_val = addr_cmp_ff;
      `AST_OFF_BAUDHI: rd_val = baud_hi_ff;
      `AST_OFF_BAUDLO: rd_val = baud_lo_ff;
      `AST_OFF_TXDATA: rd_val = 8'h00;
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `AST_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_val};
      rresp_ff <= rd_hit ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // shared divider: 16x bit clock for both directions, or a plain timer
  assign timer_active = ctrl1_ff[`AST_C1_TIMER_EN] & ~transmit_enable
    & ~receive_enable;
  assign baud_run = transmit_enable | receive_enable | timer_active;
  assign tick = baud_run && (baud_cnt_ff <= 16'h0001);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      baud_cnt_ff <= `AST_BAUD_RST;
    else if (!baud_run || tick)
      baud_cnt_ff <= {baud_hi_ff, baud_lo_ff};
    else
      baud_cnt_ff <= baud_cnt_ff - 16'h0001;
  end
  // cleared by reading the second status register; a new tick wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_flag_ff <= 1'b0;
    else if (timer_active && tick)
      timer_flag_ff <= 1'b1;
    else if (rd_go && s_axi_araddr == `AST_OFF_STAT1)
      timer_flag_ff <= 1'b0;
  end
  assign timer_irq = timer_flag_ff;

  // transmit holding register
  // setup must not wrap at a bit end, or the lead count never completes
  assign tx_bit_done = tick && (tx_sub_ff == `AST_TICKS_PER_BIT - 5'h01)
    && (tx_state_ff != ast_pkg::TX_SETUP);
  assign tx_leave_start = tx_bit_done && tx_state_ff == ast_pkg::TX_START;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      thr_full_ff <= 1'b0;
      thr_ff <= 8'h00;
      thr_mp_ff <= 1'b0;
    end
    else if (wr_go && wstrb0_ff && awaddr_ff == `AST_OFF_TXDATA
      && !thr_full_ff)
    begin
      thr_full_ff <= 1'b1;
      thr_ff <= wdata_ff;
      thr_mp_ff <= addr_bit_tx;
    end
    else if (tx_leave_start)
      thr_full_ff <= 1'b0;
  end
  assign tx_irq = transmit_enable & ~thr_full_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cts_n_ff <= 1'b1;
    else
      cts_n_ff <= cts_n;
  end
  assign cts_ok = ~flow_control_enable | ~cts_n_ff;

  // transmitter
  assign tx_load = thr_full_ff && cts_ok && tick
    && ((tx_state_ff == ast_pkg::TX_SETUP && tx_sub_ff == `AST_LEAD_TICKS)
    || (tx_state_ff == ast_pkg::TX_STOP && tx_bit_done
    && tx_stop_cnt_ff == two_stop));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_ff <= ast_pkg::TX_IDLE;
      tx_sub_ff <= 5'h00;
      tx_bit_ff <= 3'h0;
      tx_stop_cnt_ff <= 1'b0;
      tx_shift_ff <= 8'h00;
      tx_nine_ff <= 1'b0;
    end
    else if (!transmit_enable)
    begin
      tx_state_ff <= ast_pkg::TX_IDLE;
      tx_sub_ff <= 5'h00;
    end
    else if (tx_load)
    begin
      tx_state_ff <= ast_pkg::TX_START;
      tx_sub_ff <= 5'h00;
      tx_shift_ff <= thr_ff;
      tx_nine_ff <= multiproc_enable ? thr_mp_ff
        : (^thr_ff) ^ parity_odd;
    end
    else
    begin
      if (tick && tx_state_ff != ast_pkg::TX_IDLE)
        tx_sub_ff <= tx_bit_done ? 5'h00 : tx_sub_ff + 5'h01;
      unique case (tx_state_ff)
        ast_pkg::TX_IDLE:
          if (thr_full_ff && cts_ok)
          begin
            tx_state_ff <= ast_pkg::TX_SETUP;
            tx_sub_ff <= 5'h00;
          end
        ast_pkg::TX_SETUP:
          if (tick && tx_sub_ff == `AST_LEAD_TICKS)
            tx_sub_ff <= `AST_LEAD_TICKS; // held off by clear-to-send
        ast_pkg::TX_START:
          if (tx_bit_done)
          begin
            tx_state_ff <= ast_pkg::TX_DATA;
            tx_bit_ff <= 3'h0;
          end
        ast_pkg::TX_DATA:
          if (tx_bit_done)
          begin
            tx_shift_ff <= tx_shift_ff >> 1;
            tx_bit_ff <= tx_bit_ff + 3'h1;
            tx_stop_cnt_ff <= 1'b0;
            if (tx_bit_ff == 3'h7)
              tx_state_ff <= ninth_on ? ast_pkg::TX_NINTH
                : ast_pkg::TX_STOP;
          end
        ast_pkg::TX_NINTH:
          if (tx_bit_done)
            tx_state_ff <= ast_pkg::TX_STOP;
        ast_pkg::TX_STOP:
          if (tx_bit_done)
          begin
            tx_stop_cnt_ff <= 1'b1;
            if (tx_stop_cnt_ff == two_stop)
              tx_state_ff <= ast_pkg::TX_IDLE;
          end
      endcase
    end
  end

  // line and driver enable; enable lags the state by two clocks so it
  // drops one clock after the line returns from the last stop bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txd_ff <= 1'b1;
      drv_pre_ff <= 1'b0;
      drv_ff <= 1'b0;
    end
    else
    begin
      unique case (tx_state_ff)
        ast_pkg::TX_START: txd_ff <= 1'b0;
        ast_pkg::TX_DATA: txd_ff <= tx_shift_ff[0];
        ast_pkg::TX_NINTH: txd_ff <= tx_nine_ff;
        default: txd_ff <= 1'b1;
      endcase
      drv_pre_ff <= tx_state_ff != ast_pkg::TX_IDLE;
      drv_ff <= drv_pre_ff;
    end
  end
  assign txd = txd_ff;
  assign driver_enable = drv_ff;

  // receiver, 16x oversampled
  assign rx_sample = tick && (rx_sub_ff == `AST_TICKS_PER_BIT - 5'h01);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_ff <= ast_pkg::RX_IDLE;
      rx_sub_ff <= 5'h00;
      rx_bit_ff <= 3'h0;
      rx_shift_ff <= 8'h00;
      rx_nine_ff <= 1'b0;
      rx_done_ff <= 1'b0;
      rx_stop_ff <= 1'b1;
    end
    else if (!receive_enable)
    begin
      rx_state_ff <= ast_pkg::RX_IDLE;
      rx_done_ff <= 1'b0;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      if (tick)
        rx_sub_ff <= rx_sample ? 5'h00 : rx_sub_ff + 5'h01;
      unique case (rx_state_ff)
        ast_pkg::RX_IDLE:
          if (!rxd)
          begin
            rx_state_ff <= ast_pkg::RX_START;
            rx_sub_ff <= 5'h00;
          end
        ast_pkg::RX_START:
          if (tick && rx_sub_ff == `AST_START_MID)
          begin
            rx_sub_ff <= 5'h00;
            rx_bit_ff <= 3'h0;
            rx_state_ff <= rxd ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
          end
        ast_pkg::RX_DATA:
          if (rx_sample)
          begin
            rx_shift_ff <= {rxd, rx_shift_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'h7)
              rx_state_ff <= ninth_on ? ast_pkg::RX_NINTH
                : ast_pkg::RX_STOP;
          end
        ast_pkg::RX_NINTH:
          if (rx_sample)
          begin
            rx_nine_ff <= rxd;
            rx_state_ff <= ast_pkg::RX_STOP;
          end
        ast_pkg::RX_STOP:
          if (rx_sample)
          begin
            rx_done_ff <= 1'b1;
            rx_stop_ff <= rxd;
            // a low stop bit must see the line go high before a new start
            rx_state_ff <= rxd ? ast_pkg::RX_IDLE : ast_pkg::RX_WAIT_HIGH;
          end
        ast_pkg::RX_WAIT_HIGH:
          if (rxd)
            rx_state_ff <= ast_pkg::RX_IDLE;
      endcase
    end
  end

  // delivery and address filtering
  assign is_break = rx_shift_ff == 8'h00 && !rx_stop_ff
    && (!ninth_on || !rx_nine_ff);
  assign is_addr = multiproc_enable & rx_nine_ff;
  assign addr_hit = rx_shift_ff == addr_cmp_ff;
  assign par_bad = parity_enable && !multiproc_enable
    && (rx_nine_ff != ((^rx_shift_ff) ^ parity_odd));
  always_comb
  begin
    deliver = 1'b1;
    if (multiproc_enable)
    begin
      unique case (addr_match_mode)
        2'b00: deliver = 1'b1;
        2'b01: deliver = is_addr;
        2'b10: deliver = is_addr ? addr_hit : in_frame_ff;
        2'b11: deliver = !is_addr && in_frame_ff;
      endcase
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      in_frame_ff <= 1'b0;
    else if (rx_done_ff && is_addr && !is_break)
      in_frame_ff <= addr_hit;
  end

  // flags cleared by reading received data; a new event wins the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_data_ff <= 8'h00;
      rx_mp_ff <= 1'b0;
      new_frame_ff <= 1'b0;
      rx_data_avail_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      par_err_ff <= 1'b0;
      overrun_ff <= 1'b0;
      break_ff <= 1'b0;
    end
    else if (rx_done_ff && is_break)
      break_ff <= 1'b1;
    else if (rx_done_ff && deliver)
    begin
      if (rx_data_avail_ff && !rd_rxdata)
        overrun_ff <= 1'b1;
      else
      begin
        rx_data_ff <= rx_shift_ff;
        rx_mp_ff <= is_addr;
        new_frame_ff <= !is_addr && multiproc_enable && addr_match_mode[1]
          && (new_frame_ff || rx_mp_ff);
      end
      rx_data_avail_ff <= 1'b1;
      frame_err_ff <= !rx_stop_ff;
      par_err_ff <= par_bad;
    end
    else if (rd_rxdata)
    begin
      rx_data_avail_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      par_err_ff <= 1'b0;
      overrun_ff <= 1'b0;
      break_ff <= 1'b0;
    end
  end
  assign rx_irq = (rx_data_avail_ff & ~err_only) | frame_err_ff
    | par_err_ff | overrun_ff | break_ff;
endmodule
`default_nettype wire

// ---- inc/ast_consts.svh ----
// register map, field positions, reset values and timing counts
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
`define AST_ADDR_W 6
`define AST_OFF_TXDATA 6'h00
`define AST_OFF_RXDATA 6'h04
`define AST_OFF_STAT0 6'h08
`define AST_OFF_CTRL0 6'h0C
`define AST_OFF_CTRL1 6'h10
`define AST_OFF_STAT1 6'h14
`define AST_OFF_ADDRCMP 6'h18
`define AST_OFF_BAUDHI 6'h1C
`define AST_OFF_BAUDLO 6'h20
`define AST_C0_TX_EN 0
`define AST_C0_RX_EN 1
`define AST_C0_FLOW 2
`define AST_C0_PAR_EN 3
`define AST_C0_PAR_ODD 4
`define AST_C0_TWO_STOP 5
`define AST_C1_MP_EN 0
`define AST_C1_ADDR_BIT 1
`define AST_C1_MODE_LO 2
`define AST_C1_MODE_HI 3
`define AST_C1_ERR_ONLY 4
`define AST_C1_TIMER_EN 5
`define AST_CTRL_RST 8'h00
`define AST_BAUD_RST 16'h0001
`define AST_RESP_OKAY 2'b00
`define AST_RESP_SLVERR 2'b10
`define AST_TICKS_PER_BIT 5'h10
`define AST_START_MID 5'h07
`define AST_LEAD_TICKS 5'h10
`endif

// ---- inc/ast_pkg.sv ----
// state types of the serial transceiver
package ast_pkg;
  typedef enum logic [2:0] {
    TX_IDLE, TX_SETUP, TX_START, TX_DATA, TX_NINTH, TX_STOP
  } ast_tx_state_e;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP, RX_WAIT_HIGH
  } ast_rx_state_e;
  typedef logic [1:0] ast_match_mode_t;
endpackage
